// ### rtl/sbbc_slave.sv
// bus slave for single and block read/write cycles with a stream fifo
// Contract
// - a single cycle moves exactly one data item before it ends
// - single cycles are optional; this slave supports them
// - read acknowledge rises from strobe only while valid read data is driven
// - slave may withhold acknowledge; master holds its outputs until it comes
// - write acknowledge accepts data; lanes captured on the acknowledged edge
// - cycle requests a shared resource, held until the master drops cycle
// - each transfer inside a block uses the plain strobe/acknowledge handshake
// - block cycles are optional; this slave supports them
// - a memory block completes one transfer per clock; a full stream fifo adds wait states, or raises retry when RETRY_ON_FULL is set
// - master waits by dropping strobe; acknowledge falls in response
// - slave may wait after any transfer by withholding acknowledge
// - in block writes data is captured on every acknowledged edge
// - termination outputs are combinational from strobe, no register
// - at most one of acknowledge, error and retry at any time
module sbbc_slave #(
	parameter int FIFO_DEPTH = 32,
	parameter int MEM_DEPTH = 64,
	parameter int CNT_W = 16,
	parameter bit RETRY_ON_FULL = 1'b0
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// bus slave inputs
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [sbbc_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [sbbc_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [sbbc_pkg::DAT_W-1:0] wb_dat_i,
	input wire logic [sbbc_pkg::TAG_W-1:0] wb_tgd_i,
	// bus slave outputs
	output logic [sbbc_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_tgd_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	output logic wb_rty_o,
	// stream drain side
	output logic st_valid_o,
	input wire logic st_ready_i,
	output logic [sbbc_pkg::DAT_W-1:0] st_data_o,
	output logic [sbbc_pkg::TAG_W-1:0] st_tag_o,
	// cycle status
	output logic owned_o,
	output logic [CNT_W-1:0] blk_count_o,
	output logic [CNT_W-1:0] last_count_o
);

	localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;
	localparam int MIX_W = $clog2(MEM_DEPTH);

	sbbc_pkg::sbbc_state_t state_r;
	sbbc_pkg::sbbc_state_t state_nxt;
	sbbc_pkg::sbbc_word_t fifo_in;
	sbbc_pkg::sbbc_word_t fifo_out;
	logic [CNT_W-1:0] blk_count_r;
	logic [CNT_W-1:0] blk_count_nxt;
	logic [CNT_W-1:0] last_count_r;
	logic [LVL_W-1:0] fifo_level;
	logic [sbbc_pkg::DAT_W-1:0] mem_rd;
	logic fifo_in_ready;
	logic fifo_out_valid;

	// even parity over a data word, used for the read tag
	function automatic logic parity_of(input logic [sbbc_pkg::DAT_W-1:0] d);
		parity_of = ^d;
	endfunction : parity_of

	// ***************************************************************
	// address decode
	// ***************************************************************

	// single and block transfers decode identically, so both kinds are served
	wire logic xfer_req = wb_cyc_i & wb_stb_i;
	wire logic hit_mem = wb_adr_i[sbbc_pkg::ADR_W-1:sbbc_pkg::REGION_LSB] ==
		sbbc_pkg::MEM_REGION;
	wire logic hit_stream = wb_adr_i == sbbc_pkg::STREAM_ADR;
	wire logic hit_none = !hit_mem && !hit_stream;
	wire logic st_wr = hit_stream & wb_we_i;
	wire logic st_blocked = st_wr & !fifo_in_ready;

	// ***************************************************************
	// termination, purely combinational from strobe
	// ***************************************************************

	// a full fifo either stalls the master with wait states or asks for retry;
	// waiting keeps ordering simple, retry frees a shared bus for others
	assign wb_ack_o = xfer_req & !hit_none & !st_blocked;
	assign wb_err_o = xfer_req & hit_none;
	assign wb_rty_o = xfer_req & st_blocked & RETRY_ON_FULL;

	// ***************************************************************
	// read data path
	// ***************************************************************

	// status word: empty, full and fill level of the stream fifo
	wire logic [sbbc_pkg::DAT_W-1:0] status_word =
		(sbbc_pkg::DAT_W)'({fifo_level, {(sbbc_pkg::ST_LEVEL_LSB - 2){1'b0}},
		!fifo_in_ready, !fifo_out_valid});

	// read data is valid whenever the acknowledge can be high
	assign wb_dat_o = hit_stream ? status_word : mem_rd;
	assign wb_tgd_o = parity_of(wb_dat_o);

	// ***************************************************************
	// write data path
	// ***************************************************************

	// storage moves only on an acknowledged edge, never with strobe low
	wire logic mem_we = wb_ack_o & wb_we_i & hit_mem;
	wire logic fifo_push_req = xfer_req & st_wr;
	assign fifo_in = {wb_tgd_i, wb_dat_i};

	sbbc_mem #(
		.DEPTH(MEM_DEPTH)
	) u_mem (
		.core_clk_i(core_clk_i),
		.wr_en_i(mem_we),
		.wr_sel_i(wb_sel_i),
		.wr_idx_i(wb_adr_i[MIX_W-1:0]),
		.wr_data_i(wb_dat_i),
		.rd_idx_i(wb_adr_i[MIX_W-1:0]),
		.rd_data_o(mem_rd)
	);

	// fifo ready feeds the acknowledge, so a slow drain stalls the master unless RETRY_ON_FULL is set
	sbbc_fifo #(
		.WIDTH($bits(sbbc_pkg::sbbc_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(fifo_push_req),
		.in_ready_o(fifo_in_ready),
		.in_data_i(fifo_in),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(st_ready_i),
		.out_data_o(fifo_out),
		.level_o(fifo_level)
	);

	assign st_valid_o = fifo_out_valid;
	assign st_data_o = fifo_out.data;
	assign st_tag_o = fifo_out.tag;

	// ***************************************************************
	// cycle tracking and ownership
	// ***************************************************************

	// ownership lasts while cycle stays high, across strobe gaps
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sbbc_pkg::SBBC_IDLE: begin
				if (wb_cyc_i) begin
					state_nxt = wb_ack_o ? sbbc_pkg::SBBC_BURST : sbbc_pkg::SBBC_OPEN;
				end
			end
			sbbc_pkg::SBBC_OPEN: begin
				if (!wb_cyc_i) begin
					state_nxt = sbbc_pkg::SBBC_IDLE;
				end else if (wb_ack_o) begin
					state_nxt = sbbc_pkg::SBBC_BURST;
				end
			end
			sbbc_pkg::SBBC_BURST: begin
				if (!wb_cyc_i) begin
					state_nxt = sbbc_pkg::SBBC_IDLE;
				end
			end
			default: state_nxt = sbbc_pkg::SBBC_IDLE;
		endcase
	end

	// transfers counted per cycle; saturates rather than wrapping
	wire logic cnt_full = &blk_count_r;
	assign blk_count_nxt = !wb_cyc_i ? '0 :
		(wb_ack_o && !cnt_full) ? CNT_W'(blk_count_r + 1'b1) : blk_count_r;

	// registers of the cycle tracker
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= sbbc_pkg::SBBC_IDLE;
			blk_count_r <= '0;
			last_count_r <= '0;
		end else begin
			state_r <= state_nxt;
			blk_count_r <= blk_count_nxt;
			if (state_r != sbbc_pkg::SBBC_IDLE && !wb_cyc_i) begin
				last_count_r <= blk_count_r;
			end
		end
	end

	assign owned_o = state_r != sbbc_pkg::SBBC_IDLE;
	assign blk_count_o = blk_count_r;
	assign last_count_o = last_count_r;

	// ***************************************************************
	// checks
	// ***************************************************************

	a_term_follows_stb: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(wb_ack_o || wb_err_o || wb_rty_o) |-> (wb_stb_i && wb_cyc_i))
		else $error("termination without strobe");

	a_ack_drops_gap: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(wb_cyc_i && !wb_stb_i) |-> !wb_ack_o)
		else $error("acknowledge held during master wait");

	a_one_terminator: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$onehot0({wb_ack_o, wb_err_o, wb_rty_o}))
		else $error("more than one terminator asserted");

	a_read_data_valid: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(wb_ack_o && !wb_we_i && hit_mem) |-> (wb_dat_o == mem_rd))
		else $error("read acknowledged without stored data");

	a_full_waits: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(xfer_req && st_wr && fifo_level == LVL_W'(FIFO_DEPTH)) |-> !wb_ack_o)
		else $error("write accepted into full fifo");

	a_write_pushes: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(wb_ack_o && st_wr && !st_valid_o) |=> (fifo_level == 1) && st_valid_o)
		else $error("acknowledged write did not reach fifo");

	a_idle_no_store: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(!wb_stb_i && !st_ready_i) |=> $stable(fifo_level))
		else $error("fifo changed with strobe low");

	a_no_wait_burst: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(xfer_req && hit_mem) [*3] |-> wb_ack_o && $past(wb_ack_o) && $past(wb_ack_o, 2))
		else $error("wait state inserted on memory burst");

	a_count_step: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(wb_ack_o && wb_cyc_i && !cnt_full) ##1 wb_cyc_i |->
		(blk_count_r == $past(blk_count_r) + 1'b1))
		else $error("transfer count did not step by one");

	a_count_clears: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!wb_cyc_i |=> (blk_count_r == '0) && !owned_o)
		else $error("cycle end left count or ownership");

endmodule : sbbc_slave

// ### rtl/sbbc_pkg.sv
// shared constants and types for the single/block bus cycle slave
package sbbc_pkg;

	// ***************************************************************
	// bus widths
	// ***************************************************************
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;
	localparam int TAG_W = 4;
	localparam int LANE_W = 8;

	// ***************************************************************
	// address map (word addresses)
	// ***************************************************************
	localparam int MEM_AW = 6;
	localparam int REGION_LSB = 6;
	localparam logic [1:0] MEM_REGION = 2'h0;
	localparam logic [ADR_W-1:0] STREAM_ADR = 8'h80;

	// ***************************************************************
	// stream status word layout
	// ***************************************************************
	localparam int ST_EMPTY_BIT = 0;
	localparam int ST_FULL_BIT = 1;
	localparam int ST_LEVEL_LSB = 8;

	// ***************************************************************
	// reset values
	// ***************************************************************
	localparam logic [DAT_W-1:0] DAT_RST = 32'h0000_0000;

	// ***************************************************************
	// types
	// ***************************************************************
	typedef struct packed {
		logic [TAG_W-1:0] tag;
		logic [DAT_W-1:0] data;
	} sbbc_word_t;

	typedef enum logic [1:0] {
		SBBC_IDLE,
		SBBC_OPEN,
		SBBC_BURST
	} sbbc_state_t;

endpackage : sbbc_pkg

// ### rtl/sbbc_fifo.sv
// synchronous valid/ready fifo in the write stream path
module sbbc_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	// fill level
	output logic [$clog2(DEPTH):0] level_o
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] level_r;

	// honest flags straight from the level count
	wire logic push = in_valid_i & in_ready_o;
	wire logic pop = out_valid_o & out_ready_i;
	assign in_ready_o = (level_r < (PW+1)'(DEPTH)); // space left while below depth
	assign out_valid_o = (level_r != '0);
	assign out_data_o = store[rd_ptr_r];
	assign level_o = level_r;

	// pointers and level; push and pop may share a cycle
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			level_r <= '0;
		end else begin
			wr_ptr_r <= push ? PW'(wr_ptr_r + 1'b1) : wr_ptr_r;
			rd_ptr_r <= pop ? PW'(rd_ptr_r + 1'b1) : rd_ptr_r;
			level_r <= (PW+1)'(level_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
		end
	end

	// storage has no reset, it is only read behind out_valid
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			store[wr_ptr_r] <= in_data_i;
		end
	end

	// a full fifo never takes a word
	a_fifo_no_overflow: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(level_r == (PW+1)'(DEPTH)) |-> !in_ready_o)
		else $error("fifo offered space while full");

endmodule : sbbc_fifo

// ### rtl/sbbc_mem.sv
// byte-lane word store with combinational read
module sbbc_mem #(
	parameter int DEPTH = 64
) (
	// clock
	input wire logic core_clk_i,
	// write port
	input wire logic wr_en_i,
	input wire logic [sbbc_pkg::SEL_W-1:0] wr_sel_i,
	input wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
	input wire logic [sbbc_pkg::DAT_W-1:0] wr_data_i,
	// read port
	input wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
	output logic [sbbc_pkg::DAT_W-1:0] rd_data_o
);

	logic [sbbc_pkg::DAT_W-1:0] word [DEPTH];

	// read is combinational so acknowledge needs no wait state
	assign rd_data_o = word[rd_idx_i];

	// only selected lanes are written
	always_ff @(posedge core_clk_i) begin
		for (int l = 0; l < sbbc_pkg::SEL_W; l++) begin
			if (wr_en_i && wr_sel_i[l]) begin
				word[wr_idx_i][l*sbbc_pkg::LANE_W +: sbbc_pkg::LANE_W] <=
					wr_data_i[l*sbbc_pkg::LANE_W +: sbbc_pkg::LANE_W];
			end
		end
	end

	// lane 0 captured on the acknowledged edge, lane 3 untouched when not selected
	a_lane_capture: assert property (@(posedge core_clk_i)
		(wr_en_i && wr_sel_i[0]) |=>
		(word[$past(wr_idx_i)][7:0] == $past(wr_data_i[7:0])))
		else $error("selected lane not captured");
	a_lane_keep: assert property (@(posedge core_clk_i)
		(wr_en_i && !wr_sel_i[3]) |=>
		(word[$past(wr_idx_i)][31:24] == $past(word[wr_idx_i][31:24])))
		else $error("unselected lane changed");

endmodule : sbbc_mem

// ### verif/sbbc_mst_model.sv
// bus master model driving single and block cycles into the slave
module sbbc_mst_model (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// master outputs
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	output logic [3:0] tgd_o,
	// slave answers
	input wire logic ack_i,
	input wire logic err_i,
	input wire logic rty_i,
	input wire logic tgd_i,
	input wire logic [31:0] dat_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// ***************************************************************
	// master transfers
	// ***************************************************************
	// strobe and cycle low from time zero so reset sees no request
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		{we_o, adr_o, sel_o, dat_o, tgd_o} = '0;
	end

	// one strobed transfer; cycle stays up so calls chain at one per clock
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
		input logic [31:0] dat, input logic [3:0] tg, output logic [31:0] rd,
		output logic [3:0] term);
		int n;
		@(negedge core_clk_i);
		cyc_o = 1'b1;
		stb_o = 1'b1;
		we_o = we;
		adr_o = adr;
		sel_o = sel;
		dat_o = dat;
		tgd_o = tg;
		term = 4'h0;
		rd = 32'h0;
		// hold all until a termination is seen, sampled settled before the edge
		for (n = 0; n < 200 && term[2:0] == 3'h0; n++) begin
			#20ns;
			term = {tgd_i, rty_i, err_i, ack_i};
			rd = dat_i;
			@(posedge core_clk_i);
		end
	endtask : xfer

	// raise cycle alone, ahead of any strobe
	task automatic open();
		@(negedge core_clk_i);
		cyc_o = 1'b1;
	endtask : open

	// master wait state: strobe low, cycle held, qualified lines scrambled
	task automatic pause(input int n);
		@(negedge core_clk_i);
		stb_o = 1'b0;
		adr_o = ~adr_o;
		dat_o = ~dat_o;
		repeat (n) @(posedge core_clk_i);
	endtask : pause

	// end of cycle; released lines show the inverse, not the last value
	task automatic done();
		@(negedge core_clk_i);
		stb_o = 1'b0;
		cyc_o = 1'b0;
		{we_o, adr_o, sel_o, dat_o} = ~{we_o, adr_o, sel_o, dat_o};
	endtask : done

endmodule : sbbc_mst_model

// ### verif/tb_top.sv
// self-checking bench for the single/block bus cycle slave
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ***************************************************************
	// bench wiring
	// ***************************************************************
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic st_ready_i = 1'b0;
	logic cyc, stb, we, tgd_o, ack, err, rty, st_valid, owned;
	logic [7:0] adr;
	logic [3:0] sel, tgd, st_tag;
	logic [31:0] dat, dat_o, st_data, rd;
	logic [15:0] blk_count, last_count;
	logic [3:0] term;
	int err_count = 0;
	int checks_done = 0;
	time t0;

	// 20 MHz clock
	always #25ns core_clk_i = ~core_clk_i;

	sbbc_slave u_sbbc_slave (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_tgd_i(tgd), .wb_dat_o(dat_o), .wb_tgd_o(tgd_o),
		.wb_ack_o(ack), .wb_err_o(err), .wb_rty_o(rty), .st_valid_o(st_valid),
		.st_ready_i(st_ready_i), .st_data_o(st_data), .st_tag_o(st_tag),
		.owned_o(owned), .blk_count_o(blk_count), .last_count_o(last_count));

	sbbc_mst_model u_mst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dat),
		.tgd_o(tgd), .ack_i(ack), .err_i(err), .rty_i(rty), .tgd_i(tgd_o), .dat_i(dat_o));

	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	// single write then single read of one word
	task automatic t_single();
		u_mst.xfer(1'b1, 8'h03, 4'hF, 32'h1234_5678, 4'h0, rd, term);
		`CHK(term[2:0], 3'h1)
		u_mst.done();
		@(negedge core_clk_i);
		`CHK(last_count, 16'h0001)
		`CHK(owned, 1'b0)
		u_mst.xfer(1'b0, 8'h03, 4'hF, 32'h0, 4'h0, rd, term);
		`CHK(term, {^32'h1234_5678, 3'h1})
		`CHK(rd, 32'h1234_5678)
		u_mst.done();
	endtask : t_single

	// partial lanes, then a master wait whose scrambled lines must be ignored
	task automatic t_lanes();
		u_mst.xfer(1'b1, 8'h05, 4'hF, 32'hAAAA_AAAA, 4'h0, rd, term);
		u_mst.xfer(1'b1, 8'h05, 4'h6, 32'h5555_5555, 4'h0, rd, term);
		u_mst.pause(3);
		`CHK({ack, err}, 2'b00)
		`CHK(owned, 1'b1)
		u_mst.xfer(1'b0, 8'h05, 4'hF, 32'h0, 4'h0, rd, term);
		`CHK(rd, 32'hAA55_55AA)
		u_mst.done();
		`CHK(blk_count, 16'h0003)
	endtask : t_lanes

	// cycle leads strobe, eight writes at full rate, eight reads back
	task automatic t_block();
		u_mst.open();
		t0 = $time;
		for (int i = 0; i < 8; i++) begin
			u_mst.xfer(1'b1, 8'h10 + i[7:0], 4'hF, 32'hB000_0000 + i, 4'h0, rd, term);
			`CHK(term[2:0], 3'h1)
		end
		`CHK($time - t0, 64'd425)
		for (int i = 0; i < 8; i++) begin
			u_mst.xfer(1'b0, 8'h10 + i[7:0], 4'hF, 32'h0, 4'h0, rd, term);
			`CHK(rd, 32'hB000_0000 + i)
		end
		u_mst.done();
		@(negedge core_clk_i);
		`CHK(last_count, 16'h0010)
	endtask : t_block

	// unmapped addresses end in error only
	task automatic t_err();
		logic [7:0] bad [3] = '{8'h40, 8'hC0, 8'h81};
		foreach (bad[i]) begin
			u_mst.xfer(1'b1, bad[i], 4'hF, 32'hDEAD_BEEF, 4'h0, rd, term);
			`CHK(term[2:0], 3'h2)
			u_mst.done();
		end
	endtask : t_err

	// fill the fifo, stall a write on full, release it by one pop, drain in order
	task automatic t_stream();
		for (int i = 0; i < 32; i++) begin
			u_mst.xfer(1'b1, 8'h80, 4'hF, 32'hA000_0000 + i, i[3:0], rd, term);
		end
		u_mst.xfer(1'b0, 8'h80, 4'hF, 32'h0, 4'h0, rd, term);
		`CHK(rd, 32'h0000_2002)
		fork
			u_mst.xfer(1'b1, 8'h80, 4'hF, 32'hA000_0020, 4'h0, rd, term);
			begin
				repeat (4) @(negedge core_clk_i);
				`CHK(ack, 1'b0)
				st_ready_i = 1'b1;
				@(negedge core_clk_i);
				st_ready_i = 1'b0;
			end
		join
		`CHK(term[2:0], 3'h1)
		u_mst.done();
		for (int i = 1; i <= 32; i++) begin
			@(negedge core_clk_i);
			`CHK({st_valid, st_tag, st_data}, {1'b1, i[3:0], 32'hA000_0000 + i})
			st_ready_i = 1'b1;
		end
		@(negedge core_clk_i);
		st_ready_i = 1'b0;
		`CHK(st_valid, 1'b0)
		u_mst.xfer(1'b0, 8'h80, 4'hF, 32'h0, 4'h0, rd, term);
		`CHK(rd, 32'h0000_0001)
		u_mst.done();
	endtask : t_stream

	// ***************************************************************
	// main sequence and watchdog
	// ***************************************************************
	initial begin
		repeat (4) @(posedge core_clk_i);
		@(negedge core_clk_i);
		sys_rst_i = 1'b0;
		t_single();
		t_lanes();
		t_block();
		t_err();
		t_stream();
		give_verdict();
	end

	// the tests need well under 300 cycles; cut a hang at 2000
	initial begin
		#100us;
		err_count++;
		give_verdict();
	end

endmodule : tb_top
